//--- core/channel_on_off_control.sv
// On/off, margin and configuration logic for four supply channels.
// Assumes a decoded command port from the serial engine on clk_sys.
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Margin follows margin field only when fault field is 01 (ignores) or 10 (honours faults); otherwise nominal.
// RL2: With bus use, control 00 is off now, 10 sequences on, 01 sequences off.
// RL3: Switch config writes on page 0xff reach every channel enabled in the page mask.
// RL4: No sequencing starts until input voltage is above its turn-on threshold.
// RL5: Initialisation interval completes before any turn-on delay starts.
// RL6: The supply-side model, not the controller, keeps a minimum off time between pin off and pin on.
// RL7: Switch config bits 7:5 read zero and ignore writes; bit 1 reads one.
// RL8: Controlled-on clear powers up with sequencing regardless of pin or command.
// RL9: Controlled-on set powers up only on enabled pin and/or command; none means never.
// RL10: Bus-use clear ignores command control field; set obeys it.
// RL11: Pin-use clear ignores control pin; set requires the selected pin asserted.
// RL12: Pin turn-off uses off delay, or turns off at once when fast-off is set.
// RL13: Cascade channel takes its pin as a sequence-on input only.
// RL14: Two-bit field selects which of four control pins drives the channel.
// RL15: Fast servo is used unless the fast-servo-off bit is set.
// RL16: Supervisor resolution is 4 mV per step, or 8 mV when bit set.
// RL17: Continuous servo only in DAC mode 00 with continuous bit set.
// RL18: Mode 00 without continuous servo re-servos on warning when enabled.
// RL19: After rise, DAC mode picks soft-connect servo, open, direct, or soft then writes.
// RL20: Enable pin weak pull-up when on if set; weak pull-down only for soft stops.
// RL21: DAC gain and trim polarity follow configuration bits 1 and 0.
// RL22: Cascade channels retry with pin low; command off then on clears fault.
// RL23: Shared fault line turn-off sets a fault-in event and raises the alert.
// RL24: Channel config bits 15 and 9:8 read zero and have no effect.
module channel_on_off_control
  import chan_onoff_pkg::*;
#(
  parameter int T_INIT_US     = 100,
  parameter int INIT_CYC      = T_INIT_US * 1000 / CLK_PERIOD_NS,
  parameter int TON_DELAY_US  = 1,
  parameter int TON_RISE_US   = 2,
  parameter int TOFF_DELAY_US = 1
) (
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  // Command port
  input  wire cmd_t                     cmd,
  input  wire logic [NUM_CH-1:0]        pageAllMask,
  input  wire logic                     clearFaults,
  output logic [15:0]                   rdData,
  // Pins
  input  wire logic [3:0]               controlPin,
  input  wire logic                     sharedFaultLineZero_b,
  input  wire logic                     vinAboveTurnOn,
  output logic                          hostAlertOutput_b,
  // Channel side
  input  wire logic [NUM_CH-1:0]        chanFault,
  input  wire logic [NUM_CH-1:0]        faultRespond,
  input  wire logic [NUM_CH-1:0]        retryReq,
  input  wire logic [NUM_CH-1:0]        targetReached,
  input  wire logic [NUM_CH-1:0]        voutWarn,
  output chan_out_t [NUM_CH-1:0]        chanOut
);

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [15:0] TON_DELAY_CYC  = 16'(TON_DELAY_US * 1000 / CLK_PERIOD_NS);
  localparam logic [15:0] TON_RISE_CYC   = 16'(TON_RISE_US * 1000 / CLK_PERIOD_NS);
  localparam logic [15:0] TOFF_DELAY_CYC = 16'(TOFF_DELAY_US * 1000 / CLK_PERIOD_NS);

  typedef struct packed {
    logic [3:0]                ctlS1;
    logic [3:0]                ctlS2;
    logic                      fltS1;
    logic                      fltS2;
    logic                      vinS1;
    logic                      vinS2;
    logic [23:0]               initCnt;
    logic                      initDone;
    op_mode_t [NUM_CH-1:0]     op;
    switch_cfg_t [NUM_CH-1:0]  sw;
    chan_cfg_t [NUM_CH-1:0]    cfg;
    chan_state_t [NUM_CH-1:0]  st;
    logic [NUM_CH-1:0][15:0]   cnt;
    logic [NUM_CH-1:0]         casLatch;
    logic [NUM_CH-1:0]         reached;
    logic [NUM_CH-1:0]         softStop;
    logic [NUM_CH-1:0]         faultEvt;
    chan_out_t [NUM_CH-1:0]    out;
    logic [15:0]               rdData;
    logic                      alert_b;
  } state_t;

  state_t q;
  state_t d;

  // ----------------------------------------
  // Decisions
  // ----------------------------------------
  function automatic logic wantOn(switch_cfg_t s, logic [1:0] ctl, logic pin);
    logic busOk;
    busOk = !s.useBus || (ctl == CTL_SEQON); // RL2 RL10
    if (!s.controlledOn) begin
      wantOn = 1'b1; // RL8
    end else if (!s.useBus && !s.usePin) begin
      wantOn = 1'b0; // RL9
    end else begin
      wantOn = busOk && (!s.usePin || pin); // RL9 RL11
    end
  endfunction

  function automatic logic [1:0] marginOf(op_mode_t o);
    if (o.margin == MARGIN_NOM) begin
      marginOf = MARGIN_NOM;
    end else if (o.margin != 2'h3 && (o.fault == FLT_IGNORE || o.fault == FLT_HONOUR)) begin
      marginOf = o.margin; // RL1
    end else begin
      marginOf = MARGIN_NOM;
    end
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic        hit;
    logic        pin;
    logic        want;
    logic        go;
    logic        busOff;
    logic        lineOff;
    logic        onLike;
    chan_cfg_t   c;
    hit     = 1'b0;
    pin     = 1'b0;
    want    = 1'b0;
    go      = 1'b0;
    busOff  = 1'b0;
    lineOff = 1'b0;
    onLike  = 1'b0;
    c       = '0;
    d       = q;
    d.ctlS1 = controlPin;
    d.ctlS2 = q.ctlS1;
    d.fltS1 = sharedFaultLineZero_b;
    d.fltS2 = q.fltS1;
    d.vinS1 = vinAboveTurnOn;
    d.vinS2 = q.vinS1;
    if (!q.initDone) begin
      if (q.initCnt == 24'h0) begin
        d.initDone = 1'b1; // RL5
      end else begin
        d.initCnt = q.initCnt - 24'h1;
      end
    end
    if (clearFaults) begin
      d.faultEvt = '0;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      hit = (cmd.page == 8'(i)) || (cmd.page == PAGE_ALL && pageAllMask[i]);
      if (cmd.write && hit && cmd.code == CMD_OP_MODE) begin
        d.op[i] = op_mode_t'(cmd.data[7:0] & OP_WMASK);
      end
      if (cmd.write && hit && cmd.code == CMD_SWITCH_CFG) begin
        d.sw[i]       = switch_cfg_t'((cmd.data[7:0] & SWITCH_WMASK) | SWITCH_ONES); // RL3 RL7
        d.casLatch[i] = 1'b0;
      end
      if (cmd.write && cmd.page == 8'(i) && cmd.code == CMD_CHAN_CFG) begin
        d.cfg[i] = chan_cfg_t'(cmd.data & CHAN_WMASK); // RL24
      end
      c   = q.cfg[i];
      pin = q.ctlS2[c.pinSel]; // RL14
      // A cascade pin can only start the channel, so it is held once seen high.
      if (c.cascadeOn && pin) begin
        d.casLatch[i] = 1'b1; // RL13
      end
      want    = wantOn(q.sw[i], q.op[i].ctl, pin || (c.cascadeOn && q.casLatch[i])); // RL13 RL22
      go      = q.initDone && q.vinS2; // RL4 RL5
      busOff  = q.sw[i].controlledOn && q.sw[i].useBus && q.op[i].ctl == CTL_OFF; // RL2
      lineOff = !q.fltS2 && faultRespond[i];
      if (q.st[i] != ST_OFF && q.st[i] != ST_FLT && (chanFault[i] || lineOff)) begin
        d.st[i]       = ST_FLT;
        d.softStop[i] = 1'b0;
        if (lineOff) begin
          d.faultEvt[i] = 1'b1; // RL23
        end
      end else begin
        case (q.st[i])
          ST_OFF: begin
            if (go && want) begin
              d.st[i]  = ST_DLYON;
              d.cnt[i] = TON_DELAY_CYC; // RL8
            end
          end
          ST_DLYON, ST_RISE, ST_ON: begin
            if (!want) begin
              d.softStop[i] = 1'b1;
              if (busOff || (q.sw[i].usePin && !pin && q.sw[i].fastOff)) begin
                d.st[i] = ST_OFF; // RL2 RL12
              end else begin
                d.st[i]  = ST_DLYOFF; // RL12
                d.cnt[i] = TOFF_DELAY_CYC;
              end
            end else if (q.st[i] == ST_ON) begin
              d.st[i] = ST_ON;
            end else if (q.cnt[i] != 16'h0) begin
              d.cnt[i] = q.cnt[i] - 16'h1;
            end else if (q.st[i] == ST_DLYON) begin
              d.st[i]  = ST_RISE;
              d.cnt[i] = TON_RISE_CYC;
            end else begin
              d.st[i] = ST_ON;
            end
          end
          ST_DLYOFF: begin
            if (busOff || q.cnt[i] == 16'h0) begin
              d.st[i] = ST_OFF;
            end else begin
              d.cnt[i] = q.cnt[i] - 16'h1;
            end
          end
          ST_FLT: begin
            if (!want) begin
              d.st[i] = ST_OFF; // RL22
            end else if (retryReq[i] && go) begin
              d.st[i]  = ST_DLYON; // RL22
              d.cnt[i] = TON_DELAY_CYC;
            end
          end
          default: begin
            d.st[i] = ST_OFF;
          end
        endcase
      end
      // Re-servo on a warning forgets that the target was met.
      if (q.st[i] != ST_ON || (c.servoOnWarn && !c.servoCont && voutWarn[i])) begin
        d.reached[i] = 1'b0; // RL18
      end else if (targetReached[i]) begin
        d.reached[i] = 1'b1;
      end
      onLike               = q.st[i] == ST_RISE || q.st[i] == ST_ON || q.st[i] == ST_DLYOFF;
      d.out[i].enOut       = onLike;
      d.out[i].enOe        = !onLike || c.wpuEn; // RL20
      d.out[i].enWeak      = onLike ? c.wpuEn : (c.wpdEn && q.softStop[i]); // RL20
      d.out[i].margin      = marginOf(q.op[i]); // RL1
      d.out[i].ignoreFaults = q.op[i].fault == FLT_IGNORE && marginOf(q.op[i]) != MARGIN_NOM; // RL1
      d.out[i].fastServoEn = !c.fastServoOff; // RL15
      d.out[i].supRes8mV   = c.supRes8mV; // RL16
      d.out[i].dacGainHigh = c.dacGainHigh; // RL21
      d.out[i].dacPolNonInv = c.dacPolNonInv; // RL21
      d.out[i].dacConnect  = q.st[i] == ST_ON && c.dacMode != DAC_OPEN; // RL19
      d.out[i].dacSoft     = q.st[i] == ST_ON && (c.dacMode == DAC_SERVO || c.dacMode == DAC_SOFT); // RL19
      d.out[i].dacWriteOk  = q.st[i] == ST_ON && (c.dacMode == DAC_DIRECT || (c.dacMode == DAC_SOFT && q.reached[i]));
      d.out[i].servoActive = q.st[i] == ST_ON && c.dacMode == DAC_SERVO && (c.servoCont || !q.reached[i]); // RL17
    end
    if (set_any(d.faultEvt)) begin
      d.alert_b = 1'b0; // RL23
    end else begin
      d.alert_b = 1'b1;
    end
    if (cmd.read) begin
      d.rdData = 16'h0;
      if (cmd.page[7:2] == 6'h0) begin
        case (cmd.code)
          CMD_OP_MODE:    d.rdData = {8'h0, q.op[cmd.page[1:0]]};
          CMD_SWITCH_CFG: d.rdData = {8'h0, q.sw[cmd.page[1:0]]}; // RL7
          CMD_CHAN_CFG:   d.rdData = q.cfg[cmd.page[1:0]]; // RL24
          default:        d.rdData = 16'h0;
        endcase
      end
    end
  end

  function automatic logic set_any(logic [NUM_CH-1:0] v);
    set_any = |v;
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q         <= '0;
      q.initCnt <= 24'(INIT_CYC);
      // The fault line idles high; resetting its synchroniser low would fake a fall.
      q.fltS1   <= 1'b1;
      q.fltS2   <= 1'b1;
      q.op      <= {NUM_CH{OP_RESET}};
      q.sw      <= {NUM_CH{SWITCH_RESET}};
      q.cfg     <= {NUM_CH{CHAN_RESET}};
      q.st      <= '{default: ST_OFF};
      q.out     <= {NUM_CH{OUT_RESET}};
      q.alert_b <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign chanOut           = q.out;
  assign rdData            = q.rdData;
  assign hostAlertOutput_b = q.alert_b;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_pinOff;
    (q.st[2] == ST_ON || q.st[2] == ST_RISE) && q.sw[2].controlledOn && !q.sw[2].useBus && q.sw[2].usePin
      && !q.cfg[2].cascadeOn;
  endsequence
  sequence s_pinLow;
    !q.ctlS2[q.cfg[2].pinSel] && !chanFault[2] && !(!q.fltS2 && faultRespond[2]);
  endsequence

  property p_global;
    cmd.write && cmd.code == CMD_SWITCH_CFG && cmd.page == PAGE_ALL && pageAllMask[1]
      |=> q.sw[1] == (($past(cmd.data[7:0]) & SWITCH_WMASK) | SWITCH_ONES);
  endproperty
  a_global: assert property (p_global) else $error("global write missed"); // RL3
  property p_fixed;
    q.sw[0].one && q.sw[0].rsv == 3'h0;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bits wrong"); // RL7
  property p_rsv;
    cmd.read && cmd.code == CMD_CHAN_CFG && cmd.page == 8'h0 |=> !rdData[15] && rdData[9:8] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read set"); // RL24
  property p_init;
    !q.initDone |-> q.st[0] == ST_OFF;
  endproperty
  a_init: assert property (p_init) else $error("sequenced before init"); // RL5
  property p_vin;
    !q.vinS2 && q.st[0] == ST_OFF |=> q.st[0] == ST_OFF;
  endproperty
  a_vin: assert property (p_vin) else $error("sequenced below threshold"); // RL4
  property p_never;
    q.sw[0].controlledOn && !q.sw[0].useBus && !q.sw[0].usePin && q.st[0] == ST_OFF [*2] |=> q.st[0] == ST_OFF;
  endproperty
  a_never: assert property (p_never) else $error("powered with no enable"); // RL9
  property p_pinOff;
    s_pinOff ##0 s_pinLow |=> q.st[2] == (q.sw[2].fastOff ? ST_OFF : ST_DLYOFF) ##1 !chanOut[2].enOut || !q.sw[2].fastOff;
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("pin off wrong"); // RL12
  property p_margin;
    q.op[0].margin == MARGIN_HI && q.op[0].fault == FLT_HONOUR ##1 $stable(q.op[0]) |-> chanOut[0].margin == MARGIN_HI;
  endproperty
  a_margin: assert property (p_margin) else $error("margin not applied"); // RL1
  property p_fltPin;
    q.st[1] == ST_FLT |=> chanOut[1].enOe && !chanOut[1].enOut && !chanOut[1].enWeak;
  endproperty
  a_fltPin: assert property (p_fltPin) else $error("fault off not fast"); // RL20
  property p_alert;
    q.fltS2 ##1 !q.fltS2 && faultRespond[1] && q.st[1] == ST_ON && !clearFaults |=> q.faultEvt[1] && !hostAlertOutput_b;
  endproperty
  a_alert: assert property (p_alert) else $error("fault-in alert missing"); // RL23

endmodule // channel_on_off_control

//--- core/chan_onoff_pkg.sv
// Constants, field layouts and carrier types of the channel on/off block.
// Assumes one clock domain at 50 MHz; the block synchronises its own pins.
package chan_onoff_pkg;

  localparam int NUM_CH        = 4;
  localparam int CLK_PERIOD_NS = 20;

  localparam logic [7:0]  CMD_OP_MODE    = 8'h01;
  localparam logic [7:0]  CMD_SWITCH_CFG = 8'h02;
  localparam logic [7:0]  CMD_CHAN_CFG   = 8'hd0;
  localparam logic [7:0]  PAGE_ALL       = 8'hff;
  localparam logic [7:0]  OP_RESET       = 8'h00;
  localparam logic [7:0]  OP_WMASK       = 8'hfc;
  localparam logic [7:0]  SWITCH_RESET   = 8'h12;
  localparam logic [7:0]  SWITCH_WMASK   = 8'h1d;
  localparam logic [7:0]  SWITCH_ONES    = 8'h02;
  localparam logic [15:0] CHAN_RESET     = 16'h0080;
  localparam logic [15:0] CHAN_WMASK     = 16'h7cff;

  localparam logic [1:0] CTL_OFF    = 2'h0;
  localparam logic [1:0] CTL_SEQOFF = 2'h1;
  localparam logic [1:0] CTL_SEQON  = 2'h2;
  localparam logic [1:0] MARGIN_NOM = 2'h0;
  localparam logic [1:0] MARGIN_LOW = 2'h1;
  localparam logic [1:0] MARGIN_HI  = 2'h2;
  localparam logic [1:0] FLT_IGNORE = 2'h1;
  localparam logic [1:0] FLT_HONOUR = 2'h2;
  localparam logic [1:0] DAC_SERVO  = 2'h0;
  localparam logic [1:0] DAC_OPEN   = 2'h1;
  localparam logic [1:0] DAC_DIRECT = 2'h2;
  localparam logic [1:0] DAC_SOFT   = 2'h3;

  typedef struct packed {
    logic [1:0] ctl;
    logic [1:0] margin;
    logic [1:0] fault;
    logic [1:0] rsv;
  } op_mode_t;

  typedef struct packed {
    logic [2:0] rsv;
    logic       controlledOn;
    logic       useBus;
    logic       usePin;
    logic       one;
    logic       fastOff;
  } switch_cfg_t;

  typedef struct packed {
    logic       rsv15;
    logic       cascadeOn;
    logic [1:0] pinSel;
    logic       fastServoOff;
    logic       supRes8mV;
    logic [1:0] rsv9;
    logic       servoCont;
    logic       servoOnWarn;
    logic [1:0] dacMode;
    logic       wpuEn;
    logic       wpdEn;
    logic       dacGainHigh;
    logic       dacPolNonInv;
  } chan_cfg_t;

  typedef enum logic [5:0] {
    ST_OFF    = 6'h01,
    ST_DLYON  = 6'h02,
    ST_RISE   = 6'h04,
    ST_ON     = 6'h08,
    ST_DLYOFF = 6'h10,
    ST_FLT    = 6'h20
  } chan_state_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] code;
    logic [7:0] page;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic       enOut;
    logic       enOe;
    logic       enWeak;
    logic [1:0] margin;
    logic       ignoreFaults;
    logic       fastServoEn;
    logic       supRes8mV;
    logic       dacConnect;
    logic       dacSoft;
    logic       dacWriteOk;
    logic       servoActive;
    logic       dacGainHigh;
    logic       dacPolNonInv;
  } chan_out_t;

  localparam chan_out_t OUT_RESET = 14'h1000;

endpackage

//--- verification/supply_side_model.sv
// Model of the supply side: control pins paced by the link clock and servo settle.
// Assumes the bench requests pin levels and the block's outputs are registered on clk_sys.
`timescale 1ns/1ps
module supply_side_model
  import chan_onoff_pkg::*;
#(
  parameter int MIN_OFF_TICKS = 4,
  parameter int SETTLE_CYC    = 6
) (
  // Clocks and reset
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     linkClk,
  // Requests from the bench
  input  wire logic [3:0]               pinReq,
  // Block outputs
  input  wire chan_out_t [NUM_CH-1:0]   chanOut,
  // Driven inputs
  output logic [3:0]                    controlPin,
  output logic [NUM_CH-1:0]             targetReached
);
  int offTicks [4];
  int settle [NUM_CH];

  // --------------------------------------------------
  // Control pins
  // --------------------------------------------------
  // A pin that went low stays low for a minimum off time before it may rise again.
  always @(posedge linkClk or negedge rst_b) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_b) begin
        controlPin[i] <= 1'b0;
        offTicks[i]   <= MIN_OFF_TICKS;
      end else begin
        if (!pinReq[i]) controlPin[i] <= 1'b0;
        else if (offTicks[i] >= MIN_OFF_TICKS) controlPin[i] <= 1'b1;
        offTicks[i] <= controlPin[i] ? 0 : offTicks[i] + 1;
      end
    end
  end

  // --------------------------------------------------
  // Servo settle
  // --------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_b || !chanOut[i].dacConnect) settle[i] <= 0;
      else if (settle[i] < SETTLE_CYC) settle[i] <= settle[i] + 1;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) targetReached[i] = (settle[i] == SETTLE_CYC);
  end
endmodule // supply_side_model

//--- verification/tb_channel_on_off_control.sv
// Self-checking bench of the channel on/off block through its command port and pins.
// Assumes a short init interval; the link clock runs at an eighth of clk_sys with a fixed phase offset.
`timescale 1ns/1ps
module tb_channel_on_off_control;
  import chan_onoff_pkg::*;
  logic                   clk_sys = 1'b0;
  logic                   linkClk;
  logic                   rst_b;
  cmd_t                   cmd;
  logic [NUM_CH-1:0]      pageAllMask;
  logic                   clearFaults;
  logic [15:0]            rdData;
  logic [3:0]             controlPin;
  logic [3:0]             pinReq;
  logic                   sharedFaultLineZero_b;
  logic                   vinAboveTurnOn;
  logic                   hostAlertOutput_b;
  logic [NUM_CH-1:0]      faultRespond;
  logic [NUM_CH-1:0]      chanFault;
  logic [NUM_CH-1:0]      retryReq;
  logic [NUM_CH-1:0]      targetReached;
  chan_out_t [NUM_CH-1:0] chanOut;
  int                     failures = 0;
  int                     checks = 0;
  int                     cycles = 0;

  always #10 clk_sys = ~clk_sys;
  initial begin
    linkClk = 1'b0;
    #7;
    forever #80 linkClk = ~linkClk;
  end

  channel_on_off_control #(.INIT_CYC(4)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .cmd(cmd),
    .pageAllMask(pageAllMask), .clearFaults(clearFaults), .rdData(rdData), .controlPin(controlPin),
    .sharedFaultLineZero_b(sharedFaultLineZero_b), .vinAboveTurnOn(vinAboveTurnOn),
    .hostAlertOutput_b(hostAlertOutput_b), .chanFault(chanFault), .faultRespond(faultRespond),
    .retryReq(retryReq), .targetReached(targetReached), .voutWarn(4'h0), .chanOut(chanOut));

  supply_side_model model_u (.clk_sys(clk_sys), .rst_b(rst_b), .linkClk(linkClk), .pinReq(pinReq),
    .chanOut(chanOut), .controlPin(controlPin), .targetReached(targetReached));

  // --------------------------------------------------
  // Tasks
  // --------------------------------------------------
  task conclude;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] c, input logic [7:0] p, input logic [15:0] d);
    @(posedge clk_sys);
    cmd <= '{1'b1, 1'b0, c, p, d};
    @(posedge clk_sys);
    cmd <= '0;
  endtask

  // The answer is registered at the read edge and stands, so it is sampled one edge later.
  task rd(input logic [7:0] c, input logic [7:0] p, input logic [15:0] e);
    @(posedge clk_sys);
    cmd <= '{1'b0, 1'b1, c, p, 16'h0};
    @(posedge clk_sys);
    cmd <= '0;
    @(posedge clk_sys);
    #1;
    cmp(rdData, e);
  endtask

  // Counts cycles until a channel's enable reaches a level; the count must lie in [lo, hi].
  task waitout(input int ch, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    #1;
    while (chanOut[ch].enOut !== lvl && n <= hi) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    checks++;
    if (n < lo || n > hi) begin
      failures++;
      $display("mismatch at %0t: enable of %0d took %0d cycles", $time, ch, n);
    end
  endtask

  task done(input string s);
    $display("test %s finished at %0t", s, $time);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  // --------------------------------------------------
  // Tests
  // --------------------------------------------------
  initial begin
    rst_b = 1'b0;
    cmd = '0;
    pageAllMask = '0;
    clearFaults = 1'b0;
    sharedFaultLineZero_b = 1'b1;
    vinAboveTurnOn = 1'b0;
    faultRespond = '0;
    chanFault = '0;
    retryReq = '0;
    pinReq = '0;
    cyc(6);
    rst_b <= 1'b1;
    cyc(2);
    rd(CMD_OP_MODE, 8'h00, 16'h0000);
    rd(CMD_SWITCH_CFG, 8'h00, 16'h0012);
    rd(CMD_CHAN_CFG, 8'h00, 16'h0080);
    rd(CMD_CHAN_CFG, 8'h05, 16'h0000);
    done("reset");
    wr(CMD_SWITCH_CFG, 8'h00, 16'h00ff);
    rd(CMD_SWITCH_CFG, 8'h00, 16'h001f);
    wr(CMD_CHAN_CFG, 8'h00, 16'hffff);
    rd(CMD_CHAN_CFG, 8'h00, 16'h7cff);
    pageAllMask <= 4'h6;
    wr(CMD_SWITCH_CFG, 8'hff, 16'h001c);
    rd(CMD_SWITCH_CFG, 8'h01, 16'h001e);
    rd(CMD_SWITCH_CFG, 8'h00, 16'h001f);
    wr(CMD_CHAN_CFG, 8'hff, 16'h1234);
    rd(CMD_CHAN_CFG, 8'h01, 16'h0080);
    wr(CMD_SWITCH_CFG, 8'h00, 16'h0012);
    wr(CMD_CHAN_CFG, 8'h00, 16'h0080);
    done("registers");
    wr(CMD_OP_MODE, 8'h00, 16'h0014);
    cyc(3);
    cmp({13'h0, chanOut[0].margin, chanOut[0].ignoreFaults}, 16'h0003);
    wr(CMD_OP_MODE, 8'h00, 16'h0028);
    cyc(3);
    cmp({13'h0, chanOut[0].margin, chanOut[0].ignoreFaults}, 16'h0004);
    wr(CMD_SWITCH_CFG, 8'h01, 16'h0002);
    cyc(100);
    cmp({15'h0, chanOut[0].enOut}, 16'h0000);
    cmp({15'h0, chanOut[1].enOut}, 16'h0000);
    vinAboveTurnOn <= 1'b1;
    waitout(1, 1'b1, 45, 65);
    done("margin and power-up");
    wr(CMD_CHAN_CFG, 8'h01, 16'h0c03);
    cyc(3);
    cmp({12'h0, chanOut[1].fastServoEn, chanOut[1].supRes8mV, chanOut[1].dacGainHigh,
         chanOut[1].dacPolNonInv}, 16'h0007);
    cyc(120);
    cmp({10'h0, chanOut[1].dacConnect, chanOut[1].dacSoft, chanOut[1].dacWriteOk, chanOut[1].servoActive,
         chanOut[1].enOe, chanOut[1].enWeak}, 16'h0030);
    wr(CMD_CHAN_CFG, 8'h01, 16'h0010);
    cyc(3);
    cmp({15'h0, chanOut[1].dacConnect}, 16'h0000);
    done("channel fields");
    wr(CMD_SWITCH_CFG, 8'h00, 16'h0018);
    cyc(100);
    cmp({15'h0, chanOut[0].enOut}, 16'h0000);
    wr(CMD_OP_MODE, 8'h00, 16'h0080);
    waitout(0, 1'b1, 45, 65);
    wr(CMD_OP_MODE, 8'h00, 16'h0000);
    waitout(0, 1'b0, 0, 4);
    wr(CMD_OP_MODE, 8'h00, 16'h0080);
    waitout(0, 1'b1, 45, 65);
    wr(CMD_OP_MODE, 8'h00, 16'h0040);
    waitout(0, 1'b0, 45, 65);
    done("bus control");
    wr(CMD_CHAN_CFG, 8'h02, 16'h3080);
    wr(CMD_SWITCH_CFG, 8'h02, 16'h0014);
    pinReq <= 4'h1;
    cyc(150);
    cmp({15'h0, chanOut[2].enOut}, 16'h0000);
    pinReq <= 4'h8;
    waitout(2, 1'b1, 45, 80);
    pinReq <= 4'h0;
    waitout(2, 1'b0, 45, 80);
    wr(CMD_SWITCH_CFG, 8'h02, 16'h0015);
    pinReq <= 4'h8;
    waitout(2, 1'b1, 45, 200);
    pinReq <= 4'h0;
    waitout(2, 1'b0, 0, 14);
    done("control pin");
    faultRespond <= 4'h2;
    sharedFaultLineZero_b <= 1'b0;
    waitout(1, 1'b0, 0, 8);
    cyc(3);
    cmp({15'h0, hostAlertOutput_b}, 16'h0000);
    sharedFaultLineZero_b <= 1'b1;
    cyc(4);
    clearFaults <= 1'b1;
    cyc(1);
    clearFaults <= 1'b0;
    cyc(4);
    cmp({15'h0, hostAlertOutput_b}, 16'h0001);
    done("shared fault line");
    wr(CMD_CHAN_CFG, 8'h03, 16'h50a0);
    wr(CMD_SWITCH_CFG, 8'h03, 16'h0014);
    pinReq <= 4'h2;
    waitout(3, 1'b1, 45, 80);
    pinReq <= 4'h0;
    cyc(70);
    cmp({15'h0, chanOut[3].enOut}, 16'h0001);
    chanFault <= 4'h8;
    waitout(3, 1'b0, 0, 4);
    chanFault <= 4'h0;
    cyc(5);
    retryReq <= 4'h8;
    cyc(1);
    retryReq <= 4'h0;
    waitout(3, 1'b1, 45, 65);
    cyc(120);
    cmp({13'h0, chanOut[3].dacConnect, chanOut[3].dacSoft, chanOut[3].dacWriteOk}, 16'h0005);
    done("cascade retry");
    conclude();
  end
endmodule // tb_channel_on_off_control
